// ==== dv/ifeb_src_model.sv ====
// partner model: peripheral sources raising one-cycle request pulses
`timescale 1ns/1ps
module ifeb_src_model
	import ifeb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic fire,
	input wire logic [IFEB_DW-1:0] fire_bits,
	output logic [IFEB_DW-1:0] src_set
);
	// request pulse
	// external inputs are taken as already routed to a pin
	// unknown before the first edge; the block is held in reset then
	always_ff @(posedge clk_sys)
		src_set <= fire ? fire_bits : 16'h0000;
endmodule

// ==== dv/ifeb_top_tb_top.sv ====
// self-checking bench for the flag and enable bank
`timescale 1ns/1ps
module ifeb_top_tb_top import ifeb_pkg::*;;
	localparam logic [15:0] MASKS [5] = '{IFEB_FLAGS4_MASK, IFEB_EN0_MASK,
		IFEB_EN1_MASK, IFEB_EN2_MASK, IFEB_EN3_MASK};
	localparam int BITS [5] = '{IFEB_BIT_CHARGE_METER, IFEB_BIT_LOW_VOLTAGE, IFEB_BIT_CHECKSUM,
		IFEB_BIT_SERIAL2_ERR, IFEB_BIT_SERIAL1_ERR};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [IFEB_AW-1:0] reg_addr = 3'h0;
	logic [IFEB_DW-1:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic fire = 1'b0;
	logic [IFEB_DW-1:0] fire_bits = 16'h0000;
	logic [IFEB_DW-1:0] fl = 16'h0000;
	logic [IFEB_DW-1:0] en4 = 16'h0000;
	logic [IFEB_GRPS*IFEB_DW*IFEB_PW-1:0] prio = '0;
	logic [IFEB_DW-1:0] reg_rdata, src_set, pg0, pg1, pg2, pg3, pg4;
	logic [IFEB_PW-1:0] top_prio;
	logic irq;
	int n_errors = 0;
	int checks_done = 0;

	initial forever #10 clk_sys = ~clk_sys;

	ifeb_src_model u_src (.clk_sys(clk_sys), .fire(fire), .fire_bits(fire_bits),
		.src_set(src_set));

	ifeb_top dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.src_set_grp4(src_set), .flags_grp0_in(fl), .flags_grp1_in(fl),
		.flags_grp2_in(fl), .flags_grp3_in(fl), .en_grp4_in(en4), .prio_fields(prio),
		.pend_grp0(pg0), .pend_grp1(pg1), .pend_grp2(pg2), .pend_grp3(pg3),
		.pend_grp4(pg4), .top_prio(top_prio), .irq(irq));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	// write then read with no idle cycle between the strobes
	task automatic wr_rd(input logic [2:0] a, input logic [15:0] d, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	task automatic pulse(input logic [15:0] b);
		@(posedge clk_sys);
		fire <= 1'b1;
		fire_bits <= b;
		@(posedge clk_sys);
		fire <= 1'b0;
		tick(3);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		n_errors++;
		summarize();
	end

	initial
	begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++)
			rd(3'(i), 16'h0000);
		chk(pg0 | pg4, 16'h0000);
		$display("test reset done");

		for (int i = 0; i < 5; i++)
		begin
			wr(3'(i), 16'hffff);
			rd(3'(i), MASKS[i]);
			wr(3'(i), 16'h0000);
			rd(3'(i), 16'h0000);
		end
		wr(3'h7, 16'hffff);
		rd(3'h7, 16'h0000);
		wr_rd(IFEB_OFS_EN1, 16'h1234, 16'h1234 & IFEB_EN1_MASK);
		wr_rd(IFEB_OFS_EN1, 16'h0000, 16'h0000);
		$display("test registers done");

		for (int k = 0; k < 5; k++)
		begin
			pulse(16'h0001 << BITS[k]);
			rd(IFEB_OFS_FLAGS4, 16'h0001 << BITS[k]);
			wr(IFEB_OFS_FLAGS4, 16'h0000);
		end
		pulse(16'hffff);
		rd(IFEB_OFS_FLAGS4, IFEB_FLAGS4_MASK);
		tick(5);
		rd(IFEB_OFS_FLAGS4, IFEB_FLAGS4_MASK);
		wr(IFEB_OFS_FLAGS4, 16'h0000);
		rd(IFEB_OFS_FLAGS4, 16'h0000);
		$display("test flags done");

		// bit2 of group0 gets priority zero, group4 bit13 gets seven
		@(posedge clk_sys);
		fl <= 16'hffff;
		en4 <= 16'h2000;
		prio <= ({80{3'h1}} & ~(240'h7 << 6)) | (240'h6 << 231);
		wr(IFEB_OFS_EN0, 16'h0005);
		wr(IFEB_OFS_EN2, 16'h0002);
		wr(IFEB_OFS_EN3, 16'h4006);
		pulse(16'h2100);
		chk(pg0, 16'h0001);
		chk(pg1, 16'h0000);
		chk(pg2, 16'h0002);
		chk(pg3, 16'h4006);
		chk(pg4, 16'h2000);
		chk({13'h0000, top_prio}, 16'h0007);
		rd(IFEB_OFS_FLAGS4, 16'h2100);
		wr(IFEB_OFS_EN0, 16'h0000);
		tick(3);
		chk(pg0, 16'h0000);
		$display("test pending done");

		wr(IFEB_OFS_EVT_MASK, 16'h0001);
		tick(2);
		chk({15'h0000, irq}, 16'h0001);
		rd(IFEB_OFS_EVT_STAT, 16'h0003);
		wr(IFEB_OFS_EVT_STAT, 16'h0003);
		tick(2);
		chk({15'h0000, irq}, 16'h0000);
		rd(IFEB_OFS_EVT_STAT, 16'h0000);
		wr(IFEB_OFS_EVT_MASK, 16'h0000);
		pulse(16'h0008);
		chk({15'h0000, irq}, 16'h0000);
		wr(IFEB_OFS_EVT_MASK, 16'h0001);
		tick(2);
		chk({15'h0000, irq}, 16'h0001);
		$display("test interrupt done");
		summarize();
	end
endmodule

// ==== rtl/ifeb_pkg.sv ====
// constants for the interrupt flag and enable bank
package ifeb_pkg;
	localparam int IFEB_DW = 16;
	localparam int IFEB_AW = 3;
	localparam int IFEB_GRPS = 5;
	localparam int IFEB_PW = 3;
	// register indices on the plain port
	localparam logic [2:0] IFEB_OFS_FLAGS4 = 3'h0;
	localparam logic [2:0] IFEB_OFS_EN0 = 3'h1;
	localparam logic [2:0] IFEB_OFS_EN1 = 3'h2;
	localparam logic [2:0] IFEB_OFS_EN2 = 3'h3;
	localparam logic [2:0] IFEB_OFS_EN3 = 3'h4;
	localparam logic [2:0] IFEB_OFS_EVT_STAT = 3'h5;
	localparam logic [2:0] IFEB_OFS_EVT_MASK = 3'h6;
	// implemented bits of each register
	localparam logic [15:0] IFEB_FLAGS4_MASK = 16'h210e;
	localparam logic [15:0] IFEB_EN0_MASK = 16'h3fef;
	localparam logic [15:0] IFEB_EN1_MASK = 16'hfe1f;
	localparam logic [15:0] IFEB_EN2_MASK = 16'h22e3;
	localparam logic [15:0] IFEB_EN3_MASK = 16'h4006;
	localparam logic [1:0] IFEB_EVT_MASK_BITS = 2'h3;
	// field positions in the fifth flag register
	localparam int IFEB_BIT_CHARGE_METER = 13;
	localparam int IFEB_BIT_LOW_VOLTAGE = 8;
	localparam int IFEB_BIT_CHECKSUM = 3;
	localparam int IFEB_BIT_SERIAL2_ERR = 2;
	localparam int IFEB_BIT_SERIAL1_ERR = 1;
	// event status bits
	localparam int IFEB_EVT_FLAG_SET = 0;
	localparam int IFEB_EVT_PEND_RISE = 1;
	// reset values
	localparam logic [15:0] IFEB_RST_REG = 16'h0000;
	localparam logic [1:0] IFEB_RST_EVT = 2'h0;
	localparam logic [2:0] IFEB_PRIO_OFF = 3'h0;
endpackage

// ==== rtl/ifeb_top.sv ====
// interrupt flag group 4 and enable groups 0-3 with pending request outputs
// Functional notes
// - group4 flags at bits 13,8,3,2,1
// - flag sets on request, holds until cleared
// - unimplemented group4 flag bits read zero
// - all bits read/write, zero after reset; the event status bits are write-one-to-clear here
// - enable group0 layout, bits 15-14 and 4 zero
// - enable group1 layout, bits 8-5 zero
// - enable group2 layout, others zero
// - enable group3 bits 14,2,1 only
// - enable gates forwarding, flag still records
// - priority 000 disables, 7 highest
`timescale 1ns/1ps
module ifeb_top
	import ifeb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [IFEB_AW-1:0] reg_addr,
	input wire logic [IFEB_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [IFEB_DW-1:0] reg_rdata,
	input wire logic [IFEB_DW-1:0] src_set_grp4,
	input wire logic [IFEB_DW-1:0] flags_grp0_in,
	input wire logic [IFEB_DW-1:0] flags_grp1_in,
	input wire logic [IFEB_DW-1:0] flags_grp2_in,
	input wire logic [IFEB_DW-1:0] flags_grp3_in,
	input wire logic [IFEB_DW-1:0] en_grp4_in,
	input wire logic [IFEB_GRPS*IFEB_DW*IFEB_PW-1:0] prio_fields,
	output logic [IFEB_DW-1:0] pend_grp0,
	output logic [IFEB_DW-1:0] pend_grp1,
	output logic [IFEB_DW-1:0] pend_grp2,
	output logic [IFEB_DW-1:0] pend_grp3,
	output logic [IFEB_DW-1:0] pend_grp4,
	output logic [IFEB_PW-1:0] top_prio,
	output logic irq
);

	localparam int NSRC = IFEB_GRPS * IFEB_DW;
	localparam int CM_SRC = 4 * IFEB_DW + IFEB_BIT_CHARGE_METER;

	logic [15:0] irq_flags_group4_r;
	logic [15:0] irq_enable_group0_r;
	logic [15:0] irq_enable_group1_r;
	logic [15:0] irq_enable_group2_r;
	logic [15:0] irq_enable_group3_r;
	logic [1:0] evt_stat_r;
	logic [1:0] evt_mask_r;
	logic [15:0] rdata_nxt;
	logic [NSRC-1:0] flag_all;
	logic [NSRC-1:0] en_all;
	logic [NSRC-1:0] pend_nxt;
	logic [NSRC-1:0] pend_r;
	logic [IFEB_PW-1:0] prio_nxt;
	logic [IFEB_PW-1:0] prio_r;
	logic any_pend_r;
	logic wr_flags4;
	logic [15:0] hw_set4;
	logic [1:0] evt_set;

	assign wr_flags4 = reg_wr && (reg_addr == IFEB_OFS_FLAGS4);
	assign hw_set4 = src_set_grp4 & IFEB_FLAGS4_MASK;

	////////////////////////////////////////////////////////////////
	// fifth flag register

	// sticky flags, set wins over clear
	// bits kept at their positions by the mask
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			irq_flags_group4_r <= IFEB_RST_REG;
		else if (wr_flags4)
			irq_flags_group4_r <= (reg_wdata & IFEB_FLAGS4_MASK) | hw_set4;
		else
			irq_flags_group4_r <= irq_flags_group4_r | hw_set4;
	end

	////////////////////////////////////////////////////////////////
	// enable registers

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			irq_enable_group0_r <= IFEB_RST_REG;
		else if (reg_wr && (reg_addr == IFEB_OFS_EN0))
			irq_enable_group0_r <= reg_wdata & IFEB_EN0_MASK;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			irq_enable_group1_r <= IFEB_RST_REG;
		else if (reg_wr && (reg_addr == IFEB_OFS_EN1))
			irq_enable_group1_r <= reg_wdata & IFEB_EN1_MASK;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			irq_enable_group2_r <= IFEB_RST_REG;
		else if (reg_wr && (reg_addr == IFEB_OFS_EN2))
			irq_enable_group2_r <= reg_wdata & IFEB_EN2_MASK;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			irq_enable_group3_r <= IFEB_RST_REG;
		else if (reg_wr && (reg_addr == IFEB_OFS_EN3))
			irq_enable_group3_r <= reg_wdata & IFEB_EN3_MASK;
	end

	////////////////////////////////////////////////////////////////
	// pending requests toward the priority logic

	// group4 enables live outside; earlier flags come in from outside
	assign flag_all = {irq_flags_group4_r, flags_grp3_in, flags_grp2_in,
		flags_grp1_in, flags_grp0_in};
	assign en_all = {en_grp4_in, irq_enable_group3_r, irq_enable_group2_r,
		irq_enable_group1_r, irq_enable_group0_r};

	genvar s;
	generate
		for (s = 0; s < NSRC; s++)
		begin : g_src
			assign pend_nxt[s] = flag_all[s] && en_all[s] &&
				(prio_fields[s*IFEB_PW +: IFEB_PW] != IFEB_PRIO_OFF);
		end
	endgenerate

	// highest live priority, 7 on top
	always_comb
	begin
		prio_nxt = IFEB_PRIO_OFF;
		for (int i = 0; i < NSRC; i++)
		begin
			if (pend_nxt[i] && (prio_fields[i*IFEB_PW +: IFEB_PW] > prio_nxt))
				prio_nxt = prio_fields[i*IFEB_PW +: IFEB_PW];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pend_r <= '0;
			prio_r <= IFEB_PRIO_OFF;
			any_pend_r <= 1'b0;
		end
		else
		begin
			pend_r <= pend_nxt;
			prio_r <= prio_nxt;
			any_pend_r <= |pend_nxt;
		end
	end

	assign pend_grp0 = pend_r[15:0];
	assign pend_grp1 = pend_r[31:16];
	assign pend_grp2 = pend_r[47:32];
	assign pend_grp3 = pend_r[63:48];
	assign pend_grp4 = pend_r[79:64];
	assign top_prio = prio_r;

	////////////////////////////////////////////////////////////////
	// event status, mask and interrupt line

	assign evt_set = {(|pend_nxt) && !any_pend_r, |hw_set4};

	// write one to clear; a new event in the same cycle survives
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			evt_stat_r <= IFEB_RST_EVT;
		else if (reg_wr && (reg_addr == IFEB_OFS_EVT_STAT))
			evt_stat_r <= (evt_stat_r & ~reg_wdata[1:0]) | evt_set;
		else
			evt_stat_r <= evt_stat_r | evt_set;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			evt_mask_r <= IFEB_RST_EVT;
		else if (reg_wr && (reg_addr == IFEB_OFS_EVT_MASK))
			evt_mask_r <= reg_wdata[1:0] & IFEB_EVT_MASK_BITS;
	end

	assign irq = |(evt_stat_r & evt_mask_r);

	////////////////////////////////////////////////////////////////
	// read port: data one cycle after the strobe, zero otherwise

	always_comb
	begin
		unique case (reg_addr)
			IFEB_OFS_FLAGS4: rdata_nxt = irq_flags_group4_r;
			IFEB_OFS_EN0: rdata_nxt = irq_enable_group0_r;
			IFEB_OFS_EN1: rdata_nxt = irq_enable_group1_r;
			IFEB_OFS_EN2: rdata_nxt = irq_enable_group2_r;
			IFEB_OFS_EN3: rdata_nxt = irq_enable_group3_r;
			IFEB_OFS_EVT_STAT: rdata_nxt = {14'h0000, evt_stat_r};
			IFEB_OFS_EVT_MASK: rdata_nxt = {14'h0000, evt_mask_r};
			default: rdata_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			reg_rdata <= IFEB_RST_REG;
		else if (reg_rd)
			reg_rdata <= rdata_nxt;
		else
			reg_rdata <= 16'h0000;
	end

	////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	property p_flag_set;
		(|hw_set4) |=>
			((irq_flags_group4_r & $past(hw_set4)) == $past(hw_set4));
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("hardware request did not set its flag");

	property p_flag_hold;
		(irq_flags_group4_r[IFEB_BIT_CHARGE_METER] && !wr_flags4)
			|=> irq_flags_group4_r[IFEB_BIT_CHARGE_METER] [*1];
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag dropped without a software write");

	property p_flag_write;
		(wr_flags4 && hw_set4 == 16'h0000)
			|=> irq_flags_group4_r == ($past(reg_wdata) & 16'h210e);
	endproperty
	a_flag_write: assert property (p_flag_write)
		else $error("flag write landed at wrong bits");

	property p_flag_rsv;
		(reg_rd && reg_addr == IFEB_OFS_FLAGS4) |=> (reg_rdata & 16'hdef1) == 16'h0000;
	endproperty
	a_flag_rsv: assert property (p_flag_rsv)
		else $error("unimplemented flag bit read nonzero");

	property p_reset_zero;
		@(posedge clk_sys) rst |=> (irq_flags_group4_r == 16'h0000 &&
			irq_enable_group0_r == 16'h0000 && irq_enable_group3_r == 16'h0000);
	endproperty
	a_reset_zero: assert property (disable iff (1'b0) p_reset_zero)
		else $error("bits not cleared by reset");

	property p_en0_write;
		(reg_wr && reg_addr == IFEB_OFS_EN0)
			|=> irq_enable_group0_r == ($past(reg_wdata) & 16'h3fef);
	endproperty
	a_en0_write: assert property (p_en0_write)
		else $error("enable group0 layout wrong");

	property p_en1_write;
		(reg_wr && reg_addr == IFEB_OFS_EN1) ##1 (reg_rd && reg_addr == IFEB_OFS_EN1)
			|=> reg_rdata == ($past(reg_wdata, 2) & 16'hfe1f);
	endproperty
	a_en1_write: assert property (p_en1_write)
		else $error("enable group1 readback wrong");

	property p_en2_write;
		(reg_wr && reg_addr == IFEB_OFS_EN2)
			|=> irq_enable_group2_r == ($past(reg_wdata) & 16'h22e3);
	endproperty
	a_en2_write: assert property (p_en2_write)
		else $error("enable group2 layout wrong");

	property p_en3_write;
		(reg_wr && reg_addr == IFEB_OFS_EN3)
			|=> irq_enable_group3_r == ($past(reg_wdata) & 16'h4006);
	endproperty
	a_en3_write: assert property (p_en3_write)
		else $error("enable group3 layout wrong");

	property p_blocked;
		(!irq_enable_group0_r[0] && !rst) |=> !pend_grp0[0];
	endproperty
	a_blocked: assert property (p_blocked)
		else $error("request forwarded while its enable is clear");

	property p_prio_off;
		(prio_fields[8:6] == IFEB_PRIO_OFF) |=> !pend_grp0[2];
	endproperty
	a_prio_off: assert property (p_prio_off)
		else $error("source with priority 000 forwarded");

	property p_pend_and;
		1'b1 |=> (pend_grp4 &
			~($past(irq_flags_group4_r) & $past(en_grp4_in))) == 16'h0000;
	endproperty
	a_pend_and: assert property (p_pend_and)
		else $error("pending differs from flag and enable");

	property p_pend_live;
		(irq_flags_group4_r[IFEB_BIT_CHARGE_METER] && en_grp4_in[IFEB_BIT_CHARGE_METER] &&
			prio_fields[CM_SRC*IFEB_PW +: IFEB_PW] != IFEB_PRIO_OFF)
			|=> pend_grp4[IFEB_BIT_CHARGE_METER];
	endproperty
	a_pend_live: assert property (p_pend_live)
		else $error("enabled request not forwarded");

	property p_irq_line;
		(evt_stat_r[IFEB_EVT_FLAG_SET] && evt_mask_r[IFEB_EVT_FLAG_SET]) |-> irq;
	endproperty
	a_irq_line: assert property (p_irq_line)
		else $error("interrupt line low with unmasked status");

	// a clear in the same cycle must not swallow the event
	property p_evt_set;
		(|hw_set4) |=> evt_stat_r[IFEB_EVT_FLAG_SET];
	endproperty
	a_evt_set: assert property (p_evt_set)
		else $error("hardware flag event lost against a clear");

	property p_rd_idle;
		!reg_rd |=> reg_rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data stood beyond its cycle");

	c_flag_set: cover property (|hw_set4 ##1 irq_flags_group4_r != 16'h0000);
	c_flag_clear: cover property (irq_flags_group4_r != 16'h0000 ##1
		wr_flags4 ##1 irq_flags_group4_r == 16'h0000);
	c_pend: cover property (pend_grp0 != 16'h0000 && top_prio == 3'h7);
	c_irq: cover property (!irq ##1 irq);

endmodule
